// ---- rtl/fbp_ctrl.sv ----
// Module: flash control register with block protection and low-power handling
`timescale 1ns/10ps
`default_nettype none

// ************************************************************
// Overview of operation
// ************************************************************
module fbp_ctrl
(
   // Clock and reset
   input  wire logic                  ref_clk,
   input  wire logic                  nrst,
   // CPU access
   input  wire fbp_pkg::fbp_bus_t     bus,
   output logic [7:0]                 ctrl_rdata,
   // Protect byte as held in the array
   input  wire logic [7:0]            protect_start_byte,
   // Pins and low-power requests
   input  wire logic                  override_high_voltage,
   input  wire fbp_pkg::fbp_power_t   power,
   // Array controls
   output fbp_pkg::fbp_ctrl_t         array_ctrl,
   output logic                       charge_pump_on,
   output logic                       standby,
   output logic                       protect_hit,
   output logic [15:0]                target_addr
);

   // ************************************************************
   // Pin synchroniser for override voltage
   // ************************************************************
   logic ovr_meta;
   logic ovr_sync;

   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         ovr_meta <= 1'b0;
         ovr_sync <= 1'b0;
      end
      else
      begin
         ovr_meta <= override_high_voltage;
         ovr_sync <= ovr_meta;
      end
   end

   // ************************************************************
   // Protection decode
   // ************************************************************
   // Used both for the target compare and for the protect byte itself
   function automatic logic fbp_protected(input logic [15:0] a, input logic [7:0] pb,
                                          input logic ovr);
      logic [15:0] start;
      start = {fbp_pkg::START_TOP_BITS, pb, fbp_pkg::START_LOW_BITS};
      if (ovr)
         fbp_protected = 1'b0;
      else if (pb == fbp_pkg::PROTECT_ERASED)
         fbp_protected = 1'b0;
      else
         fbp_protected = (a >= start) || (a == fbp_pkg::PROTECT_BYTE_ADDR);
   endfunction : fbp_protected

   // Start address kept as a net so the checks below can see the boundary
   logic [15:0] protect_start;
   assign protect_start = {fbp_pkg::START_TOP_BITS, protect_start_byte,
                           fbp_pkg::START_LOW_BITS};

   // ************************************************************
   // Sequence tracking
   // ************************************************************
   fbp_pkg::fbp_seq_t seq;
   fbp_pkg::fbp_ctrl_t ctrl;
   logic               select_any;
   logic               ctrl_wr;
   logic               array_wr;
   logic               pb_rd;
   logic               next_high_voltage_enable;
   logic               low_power;

   assign select_any = ctrl.program_select | ctrl.erase;
   assign ctrl_wr    = bus.wr && (bus.addr == fbp_pkg::CTRL_ADDR);
   assign array_wr   = bus.wr && (bus.addr != fbp_pkg::CTRL_ADDR);
   assign pb_rd      = bus.rd && (bus.addr == fbp_pkg::PROTECT_BYTE_ADDR);
   assign low_power  = power.wait_mode | power.stop_mode;

   // Protect byte read then target write, after a select was set
   // Clearing the selects or stop drops back to read, so no stale arming survives
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
         seq <= fbp_pkg::FBP_READ;
      else if (!select_any || power.stop_mode)
         seq <= fbp_pkg::FBP_READ;
      else
      begin
         case (seq)
            fbp_pkg::FBP_READ:    seq <= pb_rd ? fbp_pkg::FBP_ARMED : fbp_pkg::FBP_READ;
            fbp_pkg::FBP_ARMED:   seq <= array_wr ? fbp_pkg::FBP_LATCHED : fbp_pkg::FBP_ARMED;
            fbp_pkg::FBP_LATCHED: seq <= fbp_pkg::FBP_LATCHED;
            default:              seq <= fbp_pkg::FBP_READ;
         endcase
      end
   end

   // Latch the first target written after arming
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
         target_addr <= fbp_pkg::ADDR_RESET;
      else if (seq == fbp_pkg::FBP_ARMED && array_wr && select_any)
         target_addr <= bus.addr;
   end

   // Protection is re-evaluated every cycle since the pin may change
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
         protect_hit <= 1'b0;
      else
         protect_hit <= fbp_protected(target_addr, protect_start_byte, ovr_sync);
   end

   // ************************************************************
   // Control register
   // ************************************************************
   // A refused enable simply stays clear; software sees the refusal on read-back
   always_comb
   begin
      next_high_voltage_enable = ctrl.high_voltage_enable;
      if (ctrl_wr)
      begin
         if (!bus.wdata[fbp_pkg::CTRL_HIGH_VOLTAGE_ENABLE_BIT])
            next_high_voltage_enable = 1'b0;
         else if (select_any && seq == fbp_pkg::FBP_LATCHED && !protect_hit)
            next_high_voltage_enable = 1'b1;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
         ctrl <= fbp_pkg::fbp_ctrl_t'(4'h0);
      else if (power.stop_mode)
         ctrl <= fbp_pkg::fbp_ctrl_t'(4'h0);
      else if (ctrl_wr)
      begin
         ctrl.high_voltage_enable <= next_high_voltage_enable;
         ctrl.mass <= bus.wdata[fbp_pkg::CTRL_MASS_BIT];
         // Interlock: a select may only be set while the other is clear
         ctrl.program_select <= bus.wdata[fbp_pkg::CTRL_PGM_BIT] &&
                                !(bus.wdata[fbp_pkg::CTRL_ERASE_BIT] || ctrl.erase);
         ctrl.erase <= bus.wdata[fbp_pkg::CTRL_ERASE_BIT] &&
                       !(bus.wdata[fbp_pkg::CTRL_PGM_BIT] || ctrl.program_select);
      end
   end

   assign ctrl_rdata = {4'h0, ctrl.high_voltage_enable, ctrl.mass, ctrl.erase,
                        ctrl.program_select};

   // ************************************************************
   // Array outputs and low-power behaviour
   // ************************************************************
   // Wait keeps the selects so software sees them; only the pump stops
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         array_ctrl     <= fbp_pkg::fbp_ctrl_t'(4'h0);
         charge_pump_on <= 1'b0;
         standby        <= 1'b0;
      end
      else
      begin
         standby        <= power.stop_mode;
         charge_pump_on <= ctrl.high_voltage_enable && !low_power;
         array_ctrl     <= power.stop_mode ? fbp_pkg::fbp_ctrl_t'(4'h0) : ctrl;
      end
   end
   // Protect byte is an input only, so no write path or reset exists

   // ************************************************************
   // Assertions
   // ************************************************************
   sequence s_armed_then_latched;
      seq == fbp_pkg::FBP_ARMED ##1 seq == fbp_pkg::FBP_LATCHED;
   endsequence

   a_high_voltage_enable_needs_sel: assert property (@(posedge ref_clk) disable iff (!nrst)
      $rose(ctrl.high_voltage_enable) |-> $past(select_any) && $past(!protect_hit))
      else $error("High voltage enabled without select or while protected");

   a_sel_exclusive: assert property (@(posedge ref_clk) disable iff (!nrst)
      !(ctrl.program_select && ctrl.erase))
      else $error("Program and erase selected together");

   a_protected_refuse: assert property (@(posedge ref_clk) disable iff (!nrst)
      ctrl_wr && protect_hit && !ctrl.high_voltage_enable |=> !ctrl.high_voltage_enable)
      else $error("High voltage set for protected target");

   a_erased_open: assert property (@(posedge ref_clk) disable iff (!nrst)
      protect_start_byte == fbp_pkg::PROTECT_ERASED && $stable(protect_start_byte)
      |=> !protect_hit)
      else $error("Erased protect byte still protects");

   a_override_open: assert property (@(posedge ref_clk) disable iff (!nrst)
      ovr_sync |=> !protect_hit)
      else $error("Override voltage did not bypass protection");

   a_top_protected: assert property (@(posedge ref_clk) disable iff (!nrst)
      !ovr_sync && protect_start_byte != fbp_pkg::PROTECT_ERASED
      && target_addr >= protect_start |=> protect_hit)
      else $error("Address above start not protected");

   a_self_locked: assert property (@(posedge ref_clk) disable iff (!nrst)
      !ovr_sync && protect_start_byte != fbp_pkg::PROTECT_ERASED
      && target_addr == fbp_pkg::PROTECT_BYTE_ADDR |=> protect_hit)
      else $error("Protect byte not self locked");

   a_wait_pump_off: assert property (@(posedge ref_clk) disable iff (!nrst)
      power.wait_mode && ctrl.high_voltage_enable |=> !charge_pump_on
      && ctrl.high_voltage_enable)
      else $error("Charge pump still on in wait");

   a_stop_standby: assert property (@(posedge ref_clk) disable iff (!nrst)
      power.stop_mode |=> standby && array_ctrl == fbp_pkg::fbp_ctrl_t'(4'h0)
      && !charge_pump_on)
      else $error("Stop did not force standby");

   a_latch_seq: assert property (@(posedge ref_clk) disable iff (!nrst)
      s_armed_then_latched |-> target_addr == $past(bus.addr))
      else $error("Target address not latched on arming write");

   // ************************************************************
   // Assertions: sequencing and low-power detail
   // ************************************************************
   // A protect byte read while a select is set arms the sequence
   sequence s_select_read;
      select_any && pb_rd && seq == fbp_pkg::FBP_READ && !power.stop_mode;
   endsequence

   sequence s_high_voltage_enable_granted;
      ctrl_wr && bus.wdata[fbp_pkg::CTRL_HIGH_VOLTAGE_ENABLE_BIT] && select_any && !power.stop_mode
      && seq == fbp_pkg::FBP_LATCHED && !protect_hit;
   endsequence

   a_read_arms: assert property (@(posedge ref_clk) disable iff (!nrst)
      s_select_read |=> seq == fbp_pkg::FBP_ARMED)
      else $error("Protect byte read did not arm the sequence");

   a_high_voltage_enable_after_seq: assert property (@(posedge ref_clk) disable iff (!nrst)
      $rose(ctrl.high_voltage_enable) |-> $past(seq) == fbp_pkg::FBP_LATCHED)
      else $error("High voltage enabled before target was latched");

   a_high_voltage_enable_grant: assert property (@(posedge ref_clk) disable iff (!nrst)
      s_high_voltage_enable_granted |=> ctrl.high_voltage_enable)
      else $error("High voltage refused for open target");

   a_below_start_open: assert property (@(posedge ref_clk) disable iff (!nrst)
      !ovr_sync && target_addr < protect_start
      && target_addr != fbp_pkg::PROTECT_BYTE_ADDR |=> !protect_hit)
      else $error("Address below start reported protected");

   a_target_hold: assert property (@(posedge ref_clk) disable iff (!nrst)
      seq != fbp_pkg::FBP_ARMED |=> $stable(target_addr))
      else $error("Target address moved outside arming");

   a_pump_with_high_voltage_enable: assert property (@(posedge ref_clk) disable iff (!nrst)
      charge_pump_on |-> array_ctrl.high_voltage_enable && !standby)
      else $error("Charge pump on without high voltage enable");

   a_wait_read_keep: assert property (@(posedge ref_clk) disable iff (!nrst)
      power.wait_mode && !power.stop_mode && !select_any
      |=> array_ctrl == $past(ctrl) && !standby)
      else $error("Wait in read mode disturbed the array controls");

   a_stop_read_standby: assert property (@(posedge ref_clk) disable iff (!nrst)
      power.stop_mode && !select_any |=> standby && !charge_pump_on)
      else $error("Stop in read mode did not enter standby");

   a_stop_seq_reset: assert property (@(posedge ref_clk) disable iff (!nrst)
      power.stop_mode |=> seq == fbp_pkg::FBP_READ && !select_any)
      else $error("Stop left the program or erase sequence armed");

endmodule : fbp_ctrl

`default_nettype wire

// ---- rtl/fbp_pkg.sv ----
// Package: constants and types for the flash block protect controller
package fbp_pkg;

   // ************************************************************
   // Register map and address shaping
   // ************************************************************
   localparam logic [15:0] PROTECT_BYTE_ADDR  = 16'hFF7E;
   localparam logic [15:0] CTRL_ADDR          = 16'hFE08;
   localparam logic [7:0]  PROTECT_ERASED     = 8'hFF;
   localparam logic [1:0]  START_TOP_BITS     = 2'h3;
   localparam logic [5:0]  START_LOW_BITS     = 6'h00;
   localparam logic [7:0]  CTRL_RESET         = 8'h00;
   localparam logic [15:0] ADDR_RESET         = 16'h0000;
   localparam int          ROW_BYTES          = 32;
   localparam int          PAGE_BYTES         = 64;

   // Control register field positions
   localparam int CTRL_PGM_BIT   = 0;
   localparam int CTRL_ERASE_BIT = 1;
   localparam int CTRL_MASS_BIT  = 2;
   localparam int CTRL_HIGH_VOLTAGE_ENABLE_BIT  = 3;

   // ************************************************************
   // Types
   // ************************************************************
   typedef enum logic [1:0] {FBP_READ, FBP_ARMED, FBP_LATCHED} fbp_seq_t;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } fbp_bus_t;

   typedef struct packed {
      logic high_voltage_enable;
      logic mass;
      logic erase;
      logic program_select;
   } fbp_ctrl_t;

   typedef struct packed {
      logic wait_mode;
      logic stop_mode;
   } fbp_power_t;

endpackage : fbp_pkg

// ---- dv/fbp_cpu_model.sv ----
// CPU side model: drives flash control accesses and holds the protect byte
`timescale 1ns/10ps
`default_nettype none
module fbp_cpu_model
(
   // Clock
   input  wire logic        ref_clk,
   // Accesses and array content
   output fbp_pkg::fbp_bus_t bus,
   output logic [7:0]        protect_start_byte
);
   // ********************
   // Array byte and bus
   // ********************
   // Array content survives reset; delivered erased
   initial
   begin
      bus = '0;
      protect_start_byte = 8'hFF;
   end

   task cyc(input logic w, input logic r, input logic [15:0] a, input logic [7:0] d);
      @(negedge ref_clk);
      bus <= '{wr: w, rd: r, addr: a, wdata: d};
      @(posedge ref_clk);
   endtask : cyc

   task idle(input int n);
      repeat (n)
      begin
         @(negedge ref_clk);
         bus <= '0;
      end
   endtask : idle

   // Stands in for a completed programming sequence on the array byte
   task program_byte(input logic [7:0] v);
      protect_start_byte = v;
   endtask : program_byte

   // One target per row, rows taken as erased; select, protect byte read and target write back to back, three idle cycles before the enable
   task arm(input logic [7:0] sel, input logic [15:0] a, input logic [7:0] d);
      cyc(1'b1, 1'b0, fbp_pkg::CTRL_ADDR, sel);
      cyc(1'b0, 1'b1, fbp_pkg::PROTECT_BYTE_ADDR, 8'h00);
      cyc(1'b1, 1'b0, a, d);
      idle(3);
      cyc(1'b1, 1'b0, fbp_pkg::CTRL_ADDR, sel | 8'h08);
      idle(2);
   endtask : arm
endmodule : fbp_cpu_model
`default_nettype wire

// ---- dv/fbp_ctrl_tb.sv ----
// Testbench for the flash block protect controller
`timescale 1ns/10ps
`default_nettype none
module fbp_ctrl_tb;
   logic                ref_clk = 1'b0;
   logic                nrst = 1'b0;
   logic                ovr = 1'b0;
   fbp_pkg::fbp_power_t power = '0;
   fbp_pkg::fbp_bus_t   bus;
   fbp_pkg::fbp_ctrl_t  array_ctrl;
   logic [7:0]          ctrl_rdata;
   logic [7:0]          pb;
   logic                charge_pump_on;
   logic                standby;
   logic                protect_hit;
   logic [15:0]         target_addr;
   logic [15:0]         a;
   logic [7:0]          sel;
   logic                hv;
   logic [7:0]          pv;
   logic [1:0]          pm;
   int                  fail_count = 0;
   int                  samples_checked = 0;
   int                  seed = 588;

   always #20 ref_clk = ~ref_clk;

   fbp_cpu_model i_fbp_cpu_model (.ref_clk(ref_clk), .bus(bus), .protect_start_byte(pb));
   fbp_ctrl i_fbp_ctrl (.ref_clk(ref_clk), .nrst(nrst), .bus(bus), .ctrl_rdata(ctrl_rdata),
      .protect_start_byte(pb), .override_high_voltage(ovr), .power(power),
      .array_ctrl(array_ctrl), .charge_pump_on(charge_pump_on), .standby(standby),
      .protect_hit(protect_hit), .target_addr(target_addr));

   // ********************
   // Checking helpers
   // ********************
   task chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         fail_count++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   function logic exp_prot(input logic [7:0] p, input logic [15:0] t, input logic o);
      logic [15:0] s;
      s = {2'b11, p, 6'h00};
      return !o && p != 8'hFF && (t >= s || t == fbp_pkg::PROTECT_BYTE_ADDR);
   endfunction : exp_prot

   task finish_test;
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : finish_test

   task do_reset;
      @(negedge ref_clk);
      nrst = 1'b0;
      power = '0;
      repeat (8) @(negedge ref_clk);
      nrst = 1'b1;
      chk({ctrl_rdata, 4'h0, array_ctrl}, 16'h0000);
   endtask : do_reset

   // ********************
   // Main sequence
   // ********************
   initial
   begin
      do_reset();
      i_fbp_cpu_model.cyc(1'b1, 1'b0, fbp_pkg::CTRL_ADDR, 8'h03);
      i_fbp_cpu_model.idle(2);
      chk(ctrl_rdata, 8'h00);
      i_fbp_cpu_model.cyc(1'b1, 1'b0, fbp_pkg::CTRL_ADDR, 8'h08);
      i_fbp_cpu_model.idle(2);
      chk(ctrl_rdata, 8'h00);
      // Skipping the protect byte read must leave the enable refused
      i_fbp_cpu_model.cyc(1'b1, 1'b0, fbp_pkg::CTRL_ADDR, 8'h01);
      i_fbp_cpu_model.cyc(1'b1, 1'b0, 16'hE000, 8'($random(seed)));
      i_fbp_cpu_model.idle(3);
      i_fbp_cpu_model.cyc(1'b1, 1'b0, fbp_pkg::CTRL_ADDR, 8'h09);
      i_fbp_cpu_model.idle(2);
      chk({ctrl_rdata, 7'h00, charge_pump_on}, 16'h0100);
      chk(target_addr, fbp_pkg::ADDR_RESET);
      i_fbp_cpu_model.cyc(1'b1, 1'b0, fbp_pkg::CTRL_ADDR, 8'h00);
      for (int i = 0; i < 60; i++)
      begin
         pv = (i % 7 == 0) ? 8'hFF : 8'($random(seed));
         i_fbp_cpu_model.program_byte(pv);
         a = {3'b111, 13'($random(seed))};
         if (i % 5 == 1) a = {2'b11, pv, 6'h00};
         if (i % 5 == 2) a = {2'b11, pv, 6'h00} - 16'h0001;
         if (i % 9 == 3) a = fbp_pkg::PROTECT_BYTE_ADDR;
         ovr = ($random(seed) % 4 == 0);
         sel = (i % 3 == 0) ? 8'h01 : {5'h00, 1'($random(seed)), 2'b10};
         pm = 2'($random(seed));
         hv = !exp_prot(pv, a, ovr);
         i_fbp_cpu_model.idle(4);
         i_fbp_cpu_model.arm(sel, a, 8'($random(seed)));
         chk(target_addr, a);
         chk(protect_hit, !hv);
         chk(ctrl_rdata, {4'h0, hv, sel[2:0]});
         chk(charge_pump_on, hv);
         if (hv && pm == 2'h1)
         begin
            power.wait_mode = 1'b1;
            i_fbp_cpu_model.idle(2);
            chk({ctrl_rdata, 7'h00, charge_pump_on}, {4'h0, 1'b1, sel[2:0], 8'h00});
            do_reset();
         end
         else if (hv && pm == 2'h2)
         begin
            power.stop_mode = 1'b1;
            i_fbp_cpu_model.idle(2);
            chk({array_ctrl, standby, charge_pump_on}, 6'b000010);
            power.stop_mode = 1'b0;
         end
         i_fbp_cpu_model.cyc(1'b1, 1'b0, fbp_pkg::CTRL_ADDR, 8'h00);
         i_fbp_cpu_model.idle(2);
      end
      power.wait_mode = 1'b1;
      i_fbp_cpu_model.idle(3);
      chk({standby, array_ctrl}, 5'b00000);
      power = 2'b01;
      i_fbp_cpu_model.idle(3);
      chk({standby, array_ctrl}, 5'b10000);
      finish_test();
   end

   // Cut a hang well past the expected run length
   initial
   begin
      #(20000 * 40);
      fail_count++;
      finish_test();
   end
endmodule : fbp_ctrl_tb
`default_nettype wire
